// File: dv/ftid_host.sv
// host spi controller model for the terminate and id bench
`timescale 1ns/100ps
module ftid_host (
    output logic            spi_cs_n,
    output logic            spi_sck,
    output logic      [3:0] sio_in,
    input  wire logic [3:0] sio_out,
    input  wire logic [3:0] sio_oe
);
    logic [3:0] host_dr;
    logic [3:0] oe_last;

    // pin level: device where enabled, else host value or toggling
    assign sio_in = (sio_oe & sio_out) | (~sio_oe & host_dr);

    initial begin
        spi_cs_n = 1'b1;
        spi_sck  = 1'b0;
        host_dr  = 4'h0;
        oe_last  = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slow clock, change on fall
    task automatic tick(input logic [3:0] v, output logic [3:0] s);
        spi_sck = 1'b0;
        host_dr = v;
        #62.5;
        spi_sck = 1'b1;
        s       = sio_in;
        oe_last = sio_oe;
        #62.5;
    endtask

    task automatic frame(input logic m3, input logic [31:0] cmd, input int nb, input int nq,
                         input int nr, input logic qr, output logic [79:0] rx);
        logic [3:0] s;
        rx      = '0;
        spi_sck = m3;
        #100;
        spi_cs_n = 1'b0;
        #100;
        for (int i = 0; i < nb; i++) begin
            tick({~host_dr[3:1], cmd[31-i]}, s);
        end
        for (int i = 0; i < nq; i++) begin
            tick(4'(i) ^ 4'hA, s);
        end
        // released lines toggle every clock
        for (int i = 0; i < nr; i++) begin
            tick(~host_dr, s);
            rx = qr ? {rx[75:0], s} : {rx[78:0], s[1]};
        end
        spi_sck = m3;
        #62.5;
        spi_cs_n = 1'b1;
        #200;
    endtask
endmodule // ftid_host

// File: dv/tb_ftid_core.sv
// self-checking bench for the terminate and id readout block
`timescale 1ns/100ps
module tb_ftid_core;
    import ftid_pkg::*;
    typedef struct {
        logic        m3;
        logic [31:0] cmd;
        int          nb;
        int          nq;
        int          nr;
        logic        qr;
        logic [79:0] rx;
        logic        teb;
        int          n_ab;
    } ftid_row_type;
    localparam logic [15:0] ID2 = {MFR_CODE, DEV_CODE1};
    localparam logic [39:0] JID = {MFR_CODE, DEV_CODE1, DEV_CODE2, EDI_LEN, EDI_VAL};
    logic        clk_sys, reset_n, spi_cs_n, spi_sck, teb, abort_op, term_busy;
    logic [3:0]  sio_in, sio_out, sio_oe;
    logic [79:0] rx;
    int          n_errors = 0, n_tests = 0, n_abort = 0, n_busy = 0;
    ftid_row_type rows [11] = '{
        '{1'b0, {OP_TERM, TERM_CONFIRM, 16'h0}, 16, 0, 0, 1'b0, 80'h0, 1'b0, 0},
        '{1'b0, {OP_WRSR, 8'h06, 8'h01, 8'h0}, 24, 0, 0, 1'b0, 80'h0, 1'b0, 0},
        '{1'b1, {OP_WRSR, SR5_ADDR, 8'h01, 8'h0}, 24, 0, 0, 1'b0, 80'h0, 1'b1, 0},
        '{1'b0, {OP_TERM, 8'hD1, 16'h0}, 16, 0, 0, 1'b0, 80'h0, 1'b1, 0},
        '{1'b0, {OP_TERM, TERM_CONFIRM, 16'h0}, 20, 0, 0, 1'b0, 80'h0, 1'b1, 0},
        '{1'b0, {OP_RDID, 24'hC3A55A}, 32, 0, 32, 1'b0, {48'h0, ID2, ID2}, 1'b1, 0},
        '{1'b1, {OP_RDID, 24'h0}, 32, 0, 32, 1'b0, {48'h0, ID2, ID2}, 1'b1, 0},
        '{1'b0, {OP_JEDEC, 24'h0}, 8, 0, 80, 1'b0, {JID, JID}, 1'b1, 0},
        '{1'b1, {OP_QRDID, 24'h0}, 8, 12, 8, 1'b1, {48'h0, ID2, ID2}, 1'b1, 0},
        '{1'b0, {OP_QRDID, 24'h0}, 8, 12, 8, 1'b1, {48'h0, ID2, ID2}, 1'b1, 0},
        '{1'b1, {OP_TERM, TERM_CONFIRM, 16'h0}, 16, 0, 0, 1'b0, 80'h0, 1'b1, 1}
    };

    ftid_core i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
        .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .terminate_enable_bit(teb),
        .abort_op(abort_op), .term_busy(term_busy)
    );
    ftid_host i_host (
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .sio_in(sio_in),
        .sio_out(sio_out), .sio_oe(sio_oe)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (abort_op === 1'b1) n_abort++;
        if (term_busy === 1'b1) n_busy++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: %s", $time, what);
        end
    endtask

    task automatic complete_run;
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        int ab;
        reset_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        check(80'({sio_oe, teb, abort_op, term_busy}), 80'h0, "reset outputs");
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        foreach (rows[k]) begin
            ab = n_abort;
            i_host.frame(rows[k].m3, rows[k].cmd, rows[k].nb, rows[k].nq, rows[k].nr,
                         rows[k].qr, rx);
            check(rx, rows[k].rx, "read data");
            check(80'(teb), 80'(rows[k].teb), "enable bit");
            check(80'(n_abort - ab), 80'(rows[k].n_ab), "abort pulses");
            check(80'(sio_oe), 80'h0, "released pins");
            if (rows[k].nr > 0) begin
                check(80'(i_host.oe_last), rows[k].qr ? 80'hF : 80'h2, "drive lanes");
            end
        end
        // terminate started promptly and runs its full span
        check(80'(term_busy), 80'h1, "busy after terminate");
        repeat (150) @(posedge clk_sys);
        check(80'(n_busy), 80'(TERM_START_CYC), "busy length");
        // second reset clears the enable, terminate refused again
        reset_n <= 1'b0;
        @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check(80'(teb), 80'h0, "enable after reset");
        ab = n_abort;
        i_host.frame(1'b0, {OP_TERM, TERM_CONFIRM, 16'h0}, 16, 0, 0, 1'b0, rx);
        check(80'(n_abort - ab), 80'h0, "refused terminate");
        complete_run();
    end

    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
endmodule // tb_ftid_core

// File: rtl/ftid_core.sv
// serial flash terminate command and identification readout
// What this block does
// - terminate ignored unless terminate enable set
// - wrong confirmation byte drops whole command
// - terminate starts promptly, other commands refused
// - terminate keeps volatile configuration unchanged
// - aborted page contents are undefined afterwards
// - mid-byte chip select release aborts command
// - valid terminate aborts operation immediately
// - 90h: opcode, three ignored dummy bytes
// - manufacturer then device code, msb first
// - repeat while selected; release floats output
// - 94h: dummy address on four lines, six clocks
// - ignored mode byte, four dummy clocks
// - four-line byte: two clocks, bit lane map
// - four-line: manufacturer, device code, repeating
// - 9Fh: opcode only, data on output line
// - 9Fh returns five bytes over forty clocks
`timescale 1ns/100ps
module ftid_core (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sck,
    input  wire logic [3:0] sio_in,
    output logic      [3:0] sio_out,
    output logic      [3:0] sio_oe,
    output logic            terminate_enable_bit,
    output logic            abort_op,
    output logic            term_busy
);
    import ftid_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0]     cs_s_r;
    logic [2:0]     sck_s_r;
    logic [3:0]     sio_s1_r;
    logic [3:0]     sio_s2_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cs_s_r   <= 3'h7;
            sck_s_r  <= 3'h0;
            sio_s1_r <= 4'h0;
            sio_s2_r <= 4'h0;
        end else begin
            cs_s_r   <= {cs_s_r[1:0], spi_cs_n};
            sck_s_r  <= {sck_s_r[1:0], spi_sck};
            sio_s1_r <= sio_in;
            sio_s2_r <= sio_s1_r;
        end
    end

    wire sel   = ~cs_s_r[1];
    wire rise  = sel & sck_s_r[1] & ~sck_s_r[2];
    wire fall  = sel & ~sck_s_r[1] & sck_s_r[2];
    wire cs_up = cs_s_r[1] & ~cs_s_r[2];

    ////////////////////////////////////////////////////////////////////////
    // command decode
    ftid_phase_type phase_r, phase_nxt;
    logic [7:0]     rcnt_r;
    logic [6:0]     shreg_r;
    logic [7:0]     opcode_r;
    logic           armed_r;
    logic           addr_ok_r;
    logic [7:0]     wrdat_r;
    logic           teb_r;
    logic           abort_r;
    logic           busy_r;
    logic [11:0]    tcnt_r;
    logic [5:0]     ptr_r;
    logic [3:0]     out_r;
    logic [3:0]     oe_r;

    wire [7:0] rcnt_nxt = rcnt_r + 8'h01;
    wire [7:0] byte_in  = {shreg_r, sio_s2_r[0]};
    wire       at_op    = rise & (phase_r == PH_CMD) & (rcnt_nxt == OPCODE_END);
    wire       op_known = (byte_in == OP_TERM) | (byte_in == OP_WRSR)
                        | (byte_in == OP_RDID) | (byte_in == OP_QRDID);
    wire       in_body  = phase_r == PH_BODY;
    wire       conf_at  = rise & in_body & (opcode_r == OP_TERM) & (rcnt_nxt == CONFIRM_END);
    wire       conf_bad = (byte_in != TERM_CONFIRM) | ~teb_r;
    wire       adr_at   = rise & in_body & (opcode_r == OP_WRSR) & (rcnt_nxt == SRADDR_END);
    wire       dat_at   = rise & in_body & (opcode_r == OP_WRSR) & (rcnt_nxt == WRSR_END);
    wire       rd_go    = rise & in_body & (opcode_r == OP_RDID) & (rcnt_nxt == RDID_START);
    // quad dummy address, mode byte and dummy clocks skipped
    wire       qrd_go   = rise & in_body & (opcode_r == OP_QRDID) & (rcnt_nxt == QRDID_START);
    // only act on a byte boundary
    wire       on_byte  = rcnt_r[2:0] == 3'h0;
    wire       term_go  = cs_up & in_body & (opcode_r == OP_TERM) & armed_r & on_byte & ~busy_r;
    wire       sr5_go   = cs_up & in_body & (opcode_r == OP_WRSR) & addr_ok_r
                        & (rcnt_r == WRSR_END) & ~busy_r;

    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            PH_CMD: begin
                if (at_op) begin
                    if (busy_r)
                        phase_nxt = PH_DROP;
                    else if (byte_in == OP_JEDEC)
                        phase_nxt = PH_OUT;
                    else if (op_known)
                        phase_nxt = PH_BODY;
                    else
                        phase_nxt = PH_DROP;
                end
            end
            PH_BODY: begin
                if ((conf_at & conf_bad) | (adr_at & (byte_in != SR5_ADDR)))
                    phase_nxt = PH_DROP;
                else if (rd_go | qrd_go)
                    phase_nxt = PH_OUT;
            end
            PH_OUT:  phase_nxt = PH_OUT;
            PH_DROP: phase_nxt = PH_DROP;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_r   <= PH_CMD;
            rcnt_r    <= 8'h00;
            shreg_r   <= 7'h00;
            opcode_r  <= 8'h00;
            armed_r   <= 1'b0;
            addr_ok_r <= 1'b0;
            wrdat_r   <= 8'h00;
        end else if (!sel) begin
            phase_r   <= PH_CMD;
            rcnt_r    <= 8'h00;
            armed_r   <= 1'b0;
            addr_ok_r <= 1'b0;
        end else if (rise) begin
            phase_r   <= phase_nxt;
            rcnt_r    <= rcnt_nxt;
            shreg_r   <= byte_in[6:0];
            if (at_op)
                opcode_r <= byte_in;
            if (conf_at)
                armed_r <= ~conf_bad;
            if (adr_at)
                addr_ok_r <= byte_in == SR5_ADDR;
            if (dat_at)
                wrdat_r <= byte_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // terminate enable and terminate sequence
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            teb_r   <= TEB_RESET;
            abort_r <= 1'b0;
            busy_r  <= 1'b0;
            tcnt_r  <= 12'h000;
        end else begin
            if (sr5_go)
                teb_r <= wrdat_r[TEB_POS];
            abort_r <= term_go;
            if (term_go) begin
                busy_r <= 1'b1;
                tcnt_r <= TERM_START_CYC;
            end else if (busy_r) begin
                tcnt_r <= tcnt_r - 12'h001;
                busy_r <= tcnt_r != 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // identification output
    wire        quad    = opcode_r == OP_QRDID;
    wire        jedec   = opcode_r == OP_JEDEC;
    wire [39:0] id_vec  = jedec ? {MFR_CODE, DEV_CODE1, DEV_CODE2, EDI_LEN, EDI_VAL}
                                : {MFR_CODE, DEV_CODE1, 24'h000000};
    wire [5:0]  wrap    = quad ? QRDID_WRAP : (jedec ? JEDEC_WRAP : RDID_WRAP);
    wire [7:0]  shamt   = quad ? {ptr_r, 2'b00} : {2'b00, ptr_r};
    wire [39:0] shifted = id_vec << shamt;
    wire [5:0]  ptr_inc = ptr_r + 6'h01;
    wire        out_now = fall & (phase_r == PH_OUT);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ptr_r <= 6'h00;
            out_r <= 4'h0;
            oe_r  <= 4'h0;
        end else if (!sel) begin
            ptr_r <= 6'h00;
            oe_r  <= 4'h0;
        end else if (out_now) begin
            ptr_r <= (ptr_inc == wrap) ? 6'h00 : ptr_inc;
            // hold, wp, so, si carry bits 7..4
            out_r <= quad ? shifted[39:36] : {2'b00, shifted[39], 1'b0};
            oe_r  <= quad ? 4'hF : 4'h2;
        end
    end

    assign sio_out              = out_r;
    assign sio_oe               = oe_r;
    assign terminate_enable_bit = teb_r;
    assign abort_op             = abort_r;
    assign term_busy            = busy_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_term_needs_enable: assert property (abort_r |-> $past(teb_r))
        else $error("terminate ran without enable");
    a_bad_confirm_drop: assert property (conf_at && conf_bad |=> phase_r == PH_DROP)
        else $error("bad confirmation not dropped");
    a_busy_refuses: assert property (busy_r && at_op |=> phase_r == PH_DROP)
        else $error("command accepted while terminating");
    a_abort_busy_win: assert property (abort_r |-> busy_r ##1 busy_r)
        else $error("terminate window too short");
    a_teb_kept: assert property (abort_r |=> $stable(teb_r))
        else $error("terminate changed configuration");
    a_midbyte_abort: assert property (cs_up && !on_byte |=> !abort_r)
        else $error("mid-byte release still terminated");
    a_abort_one_pulse: assert property (abort_r |=> !abort_r)
        else $error("abort pulse longer than a cycle");
    a_single_lane: assert property (oe_r != 4'h0 && !quad |-> oe_r == 4'h2)
        else $error("single read drives extra lines");
    a_release_float: assert property (cs_up |=> oe_r == 4'h0)
        else $error("output not released");
    a_quad_start: assert property (qrd_go |=> phase_r == PH_OUT ##0 oe_r == 4'h0)
        else $error("quad read did not start at clock 20");
    a_quad_lanes: assert property (oe_r != 4'h0 && quad |-> oe_r == 4'hF)
        else $error("quad read lanes wrong");
    a_jedec_wrap: assert property (ptr_r < JEDEC_WRAP)
        else $error("id pointer out of range");

endmodule // ftid_core

// File: rtl/ftid_pkg.sv
// constants for the terminate and identification command logic
package ftid_pkg;
    // opcodes and command bytes
    localparam logic [7:0] OP_TERM      = 8'hF0;
    localparam logic [7:0] TERM_CONFIRM = 8'hD0;
    localparam logic [7:0] OP_WRSR      = 8'h71;
    localparam logic [7:0] SR5_ADDR     = 8'h05;
    localparam logic [7:0] OP_RDID      = 8'h90;
    localparam logic [7:0] OP_QRDID     = 8'h94;
    localparam logic [7:0] OP_JEDEC     = 8'h9F;
    // terminate_enable_bit position inside the status byte
    localparam int         TEB_POS      = 0;
    localparam logic       TEB_RESET    = 1'b0;
    // identification bytes; values are arbitrary
    localparam logic [7:0] MFR_CODE     = 8'hA5;
    localparam logic [7:0] DEV_CODE1    = 8'h3C;
    localparam logic [7:0] DEV_CODE2    = 8'h51;
    localparam logic [7:0] EDI_LEN      = 8'h01;
    localparam logic [7:0] EDI_VAL      = 8'h00;
    // rising serial clock counts at phase boundaries
    localparam logic [7:0] OPCODE_END   = 8'h08;
    localparam logic [7:0] CONFIRM_END  = 8'h10;
    localparam logic [7:0] SRADDR_END   = 8'h10;
    localparam logic [7:0] WRSR_END     = 8'h18;
    localparam logic [7:0] RDID_START   = 8'h20;
    localparam logic [7:0] QRDID_START  = 8'h14;
    // output pointer wrap points
    localparam logic [5:0] RDID_WRAP    = 6'h10;
    localparam logic [5:0] JEDEC_WRAP   = 6'h28;
    localparam logic [5:0] QRDID_WRAP   = 6'h04;
    // timing
    localparam int          CLK_MHZ        = 100;
    localparam int          TERM_START_NS  = 1000;
    localparam int          TERM_CYC_INT   = (TERM_START_NS * CLK_MHZ) / 1000;
    localparam logic [11:0] TERM_START_CYC = 12'(TERM_CYC_INT < 1 ? 1 : TERM_CYC_INT);

    typedef enum logic [1:0] {
        PH_CMD  = 2'b00,
        PH_BODY = 2'b01,
        PH_OUT  = 2'b10,
        PH_DROP = 2'b11
    } ftid_phase_type;
endpackage
